// >>> core/vsg_translator.sv
// Inbound VME-to-PCI scatter-gather translator with map RAM and base regs.
module vsg_translator
    import vsg_pkg::*;
#(
    parameter int MON_W  = 10,
    parameter int COMM_N = 8
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        cfg_req,
    input  wire logic        cfg_we,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic      [31:0] cfg_rdata,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata,
    input  wire logic        vme_req,
    input  wire logic        vme_write,
    input  wire logic [5:0]  vme_am,
    input  wire logic [31:0] vme_addr,
    input  wire logic [7:0]  vme_wdata,
    output logic             vme_ack,
    output logic             vme_berr,
    output logic      [31:0] vme_rdata,
    output logic             pci_req,
    output logic      [31:0] pci_addr,
    output logic             pci_io,
    output logic             pci_we,
    input  wire logic        pci_done,
    input  wire logic [31:0] pci_rdata
);
    vsg_state_e  state_r;
    logic [31:0] if_base_r, w1_base_r, sg_base_r, w2_base_r;
    logic [26:0] map_mem [0:VSG_MAP_WORDS-1];
    logic [26:0] ram_q;
    logic [14:0] ram_ra;
    logic [31:0] entry;
    logic [MON_W-1:0] mon_r [1:3];
    logic [7:0]  comm_r [0:COMM_N-1];
    logic        cfg_ack_r, mem_ack_r, vme_ack_r, vme_berr_r;
    logic        pci_req_r, pci_io_r, pci_we_r, vme_wr_r, vme_sup_r;
    logic [31:0] cfg_rdata_r, mem_rdata_r, vme_rdata_r, pci_addr_r;
    logic [12:2] vme_ofs_r;
    logic        is_a32, is_a24, is_a16, sg_hit, if_hit, take_vme;
    logic [14:0] vme_idx;
    logic        deny;

    assign entry = {ram_q, {VSG_ZERO_BITS{1'b0}}};
    assign is_a32 = vme_am[5:3] == VSG_AM_A32;
    assign is_a24 = vme_am[5:3] == VSG_AM_A24;
    assign is_a16 = vme_am == VSG_AM_A16_USER || vme_am == VSG_AM_A16_SUPER;
    assign sg_hit = (mem_addr & VSG_SG_WMASK) == sg_base_r;
    assign if_hit = (mem_addr & VSG_IF_WMASK) == if_base_r;
    assign take_vme = state_r == VSG_IDLE && vme_req;

    // An A32 index never reaches the A24 region: bits 26:13 give 16384 slots.
    always_comb begin
        if (is_a24) begin
            vme_idx = VSG_A24_IDX_BASE + {4'h0, vme_addr[23:13]};
        end else begin
            vme_idx = VSG_A32_IDX_BASE + {1'b0, vme_addr[26:13]};
        end
        ram_ra = take_vme ? vme_idx : mem_addr[16:2];
    end

    // Entry checks made on the looked-up entry.
    always_comb begin
        deny = !entry[VSG_E_VALID];
        if (entry[VSG_E_WLOCK] && vme_wr_r) begin
            deny = 1'b1;
        end
        if (entry[VSG_E_SUPER] && !vme_sup_r) begin
            deny = 1'b1;
        end
    end

    // The map RAM has no reset; contents are random until software fills
    // every entry, outbound region at VSG_OUT_IDX_BASE included.
    always_ff @(posedge clk_sys) begin
        if (state_r == VSG_IDLE && !vme_req && mem_req && mem_we && sg_hit)
        begin
            map_mem[mem_addr[16:2]] <= mem_wdata[31:VSG_ZERO_BITS];
        end
        ram_q <= map_mem[ram_ra];
    end

    // Base registers: configuration cycles only, masked writes.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            if_base_r   <= VSG_BASE_RST;
            w1_base_r   <= VSG_BASE_RST;
            sg_base_r   <= VSG_BASE_RST;
            w2_base_r   <= VSG_BASE_RST;
            cfg_ack_r   <= 1'b0;
            cfg_rdata_r <= 32'h0000_0000;
        end else begin
            cfg_ack_r <= cfg_req && !cfg_ack_r;
            if (cfg_req && !cfg_ack_r) begin
                case (cfg_addr)
                    VSG_CFG_IF_OFS: begin
                        cfg_rdata_r <= if_base_r;
                        if (cfg_we) begin
                            if_base_r <= cfg_wdata & VSG_IF_WMASK;
                        end
                    end
                    VSG_CFG_W1_OFS: begin
                        cfg_rdata_r <= w1_base_r;
                        if (cfg_we) begin
                            w1_base_r <= cfg_wdata & VSG_W1_WMASK;
                        end
                    end
                    VSG_CFG_SG_OFS: begin
                        cfg_rdata_r <= sg_base_r;
                        if (cfg_we) begin
                            sg_base_r <= cfg_wdata & VSG_SG_WMASK;
                        end
                    end
                    VSG_CFG_W2_OFS: begin
                        cfg_rdata_r <= w2_base_r;
                        if (cfg_we) begin
                            w2_base_r <= cfg_wdata & VSG_W2_WMASK;
                        end
                    end
                    default: cfg_rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Main sequencer: VME has priority over PCI memory accesses.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_r     <= VSG_IDLE;
            mem_ack_r   <= 1'b0;
            mem_rdata_r <= 32'h0000_0000;
            vme_ack_r   <= 1'b0;
            vme_berr_r  <= 1'b0;
            vme_rdata_r <= 32'h0000_0000;
            vme_wr_r    <= 1'b0;
            vme_sup_r   <= 1'b0;
            vme_ofs_r   <= 11'h000;
            pci_req_r   <= 1'b0;
            pci_addr_r  <= 32'h0000_0000;
            pci_io_r    <= 1'b0;
            pci_we_r    <= 1'b0;
        end else begin
            case (state_r)
                VSG_IDLE: begin
                    if (vme_req) begin
                        vme_wr_r  <= vme_write;
                        vme_sup_r <= vme_am[VSG_AM_SUPER_BIT];
                        vme_ofs_r <= vme_addr[12:2];
                        if (is_a16) begin
                            vme_ack_r   <= 1'b1;
                            vme_rdata_r <= {24'h000000,
                                comm_r[vme_addr[$clog2(COMM_N)-1:0]]};
                            state_r     <= VSG_DONE;
                        end else if (is_a32 || is_a24) begin
                            state_r <= VSG_CHECK;
                        end else begin
                            vme_berr_r <= 1'b1;
                            state_r    <= VSG_DONE;
                        end
                    end else if (mem_req) begin
                        if (sg_hit && !mem_we) begin
                            state_r <= VSG_MRD;
                        end else begin
                            mem_ack_r   <= 1'b1;
                            mem_rdata_r <= 32'h0000_0000;
                            if (if_hit && mem_addr[8:0] == VSG_PMON_OFS) begin
                                mem_rdata_r <= 32'({mon_r[3], mon_r[2],
                                                    mon_r[1]});
                            end
                            state_r <= VSG_DONE;
                        end
                    end
                end
                VSG_CHECK: begin
                    if (deny) begin
                        vme_berr_r <= 1'b1;
                        state_r    <= VSG_DONE;
                    end else begin
                        pci_req_r  <= 1'b1;
                        pci_addr_r <= {1'b0, entry[31:VSG_E_PAGE_LO],
                                       vme_ofs_r, 2'b00};
                        pci_io_r   <= entry[VSG_E_IOSEL];
                        pci_we_r   <= vme_wr_r;
                        state_r    <= VSG_PCI;
                    end
                end
                VSG_PCI: begin
                    pci_req_r <= 1'b0;
                    if (pci_done) begin
                        vme_ack_r   <= 1'b1;
                        vme_rdata_r <= pci_rdata;
                        state_r     <= VSG_DONE;
                    end
                end
                VSG_MRD: begin
                    mem_ack_r   <= 1'b1;
                    mem_rdata_r <= entry;
                    state_r     <= VSG_DONE;
                end
                VSG_DONE: begin
                    mem_ack_r  <= 1'b0;
                    vme_ack_r  <= 1'b0;
                    vme_berr_r <= 1'b0;
                    state_r    <= VSG_IDLE;
                end
                default: state_r <= VSG_IDLE;
            endcase
        end
    end

    // Page monitor counters wrap silently; software must sample them often.
    generate
        for (genvar m = 1; m <= 3; m++) begin : g_mon
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    mon_r[m] <= '0;
                end else if (state_r == VSG_CHECK && !deny &&
                    entry[VSG_E_MON_LO+1:VSG_E_MON_LO] == 2'(m)) begin
                    mon_r[m] <= mon_r[m] + 1'b1;
                end
            end
        end
        for (genvar c = 0; c < COMM_N; c++) begin : g_comm
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    comm_r[c] <= 8'h00;
                end else if (take_vme && is_a16 && vme_write &&
                    vme_addr[$clog2(COMM_N)-1:0] == ($clog2(COMM_N))'(c))
                begin
                    comm_r[c] <= vme_wdata;
                end
            end
        end
    endgenerate

    assign cfg_ack   = cfg_ack_r;
    assign cfg_rdata = cfg_rdata_r;
    assign mem_ack   = mem_ack_r;
    assign mem_rdata = mem_rdata_r;
    assign vme_ack   = vme_ack_r;
    assign vme_berr  = vme_berr_r;
    assign vme_rdata = vme_rdata_r;
    assign pci_req   = pci_req_r;
    assign pci_addr  = pci_addr_r;
    assign pci_io    = pci_io_r;
    assign pci_we    = pci_we_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_denied;
        state_r == VSG_CHECK && deny;
    endsequence
    sequence s_berr_only;
        vme_berr_r && !pci_req_r ##1 !vme_berr_r;
    endsequence

    deny_berr_a: assert property (s_denied |=> s_berr_only)
        else $error("denied entry did not end in bus error");
    write_lock_a: assert property (state_r == VSG_CHECK && vme_wr_r &&
        entry[VSG_E_WLOCK] |=> vme_berr_r && !pci_req_r)
        else $error("write to locked page was not refused");
    super_only_a: assert property (state_r == VSG_CHECK && !vme_sup_r &&
        entry[VSG_E_SUPER] |=> vme_berr_r)
        else $error("user cycle reached supervisor page");
    io_select_a: assert property (state_r == VSG_CHECK && !deny |=>
        pci_req_r && pci_io_r == $past(entry[VSG_E_IOSEL]))
        else $error("cycle type does not follow entry");
    // The read port follows the memory side again once the check is done,
    // so the page field is compared with the entry seen one cycle earlier.
    pci_addr_a: assert property (pci_req_r |-> !pci_addr_r[31] &&
        pci_addr_r[1:0] == 2'b00 &&
        pci_addr_r[30:13] == $past(entry[31:14]))
        else $error("bad inbound pci address");
    mon_count_a: assert property (state_r == VSG_CHECK && !deny &&
        entry[13:12] == 2'd1 |=> mon_r[1] == $past(mon_r[1]) + 1'b1)
        else $error("monitor 1 did not count");
    base_mask_a: assert property (if_base_r[8:0] == 9'h000 &&
        w1_base_r[28:0] == 29'h0 && w2_base_r[25:0] == 26'h0)
        else $error("read-only base bits were written");
    a16_reply_a: assert property (take_vme && is_a16 |=>
        vme_ack_r && !vme_berr_r ##1 !vme_ack_r)
        else $error("A16 cycle not answered");
    pci_done_a: assert property (pci_req_r |=> !pci_req_r)
        else $error("pci request longer than one cycle");

    // Each answer is a single pulse, so a request still held on the next
    // edge is not taken a second time.
    sequence s_cfg_taken;
        cfg_req && !cfg_ack_r;
    endsequence
    sequence s_cfg_pulse;
        cfg_ack_r ##1 !cfg_ack_r;
    endsequence
    sequence s_map_read;
        state_r == VSG_IDLE && !vme_req && mem_req && sg_hit && !mem_we;
    endsequence

    cfg_pulse_a: assert property (s_cfg_taken |=> s_cfg_pulse)
        else $error("config answer is not a single pulse");
    if_write_a: assert property (cfg_req && !cfg_ack_r && cfg_we &&
        cfg_addr == VSG_CFG_IF_OFS |=>
        if_base_r == ($past(cfg_wdata) & VSG_IF_WMASK))
        else $error("interface base write not masked");
    w1_write_a: assert property (cfg_req && !cfg_ack_r && cfg_we &&
        cfg_addr == VSG_CFG_W1_OFS |=>
        w1_base_r == ($past(cfg_wdata) & VSG_W1_WMASK))
        else $error("large window base write not masked");
    sg_write_a: assert property (cfg_req && !cfg_ack_r && cfg_we &&
        cfg_addr == VSG_CFG_SG_OFS |=>
        sg_base_r == ($past(cfg_wdata) & VSG_SG_WMASK))
        else $error("map window base write not masked");
    w2_write_a: assert property (cfg_req && !cfg_ack_r && cfg_we &&
        cfg_addr == VSG_CFG_W2_OFS |=>
        w2_base_r == ($past(cfg_wdata) & VSG_W2_WMASK))
        else $error("small window base write not masked");
    map_read_a: assert property (s_map_read |=> ##1 mem_ack_r)
        else $error("map read not answered in two cycles");
    zero_bits_a: assert property (state_r == VSG_MRD |=>
        mem_rdata_r[4:0] == 5'h00)
        else $error("low entry bits read back nonzero");
    bad_am_a: assert property (take_vme && !is_a16 && !is_a32 && !is_a24
        |=> vme_berr_r && !vme_ack_r)
        else $error("unknown address modifier not refused");

    // An A24 slot must never alias an A32 one, or one master could reach
    // pages that were mapped only for the other space.
    a24_index_a: assert property (take_vme && is_a24 |->
        ram_ra == (VSG_A24_IDX_BASE | {4'h0, vme_addr[23:13]}))
        else $error("A24 entry index wrong");
    a32_index_a: assert property (take_vme && is_a32 |->
        ram_ra == {1'b0, vme_addr[26:13]})
        else $error("A32 entry index wrong");
    answer_excl_a: assert property (!(vme_ack_r && vme_berr_r))
        else $error("ack and bus error together");
    mon_hold_a: assert property (state_r != VSG_CHECK |=>
        mon_r[2] == $past(mon_r[2]))
        else $error("monitor 2 moved without an access");
    a16_data_a: assert property (take_vme && is_a16 |=>
        vme_rdata_r[31:8] == 24'h000000)
        else $error("communication read not byte wide");
endmodule // vsg_translator

// >>> core/vsg_pkg.sv
// Constants for the inbound scatter-gather translator.
package vsg_pkg;
    // Configuration-space offsets of the four base registers.
    localparam logic [11:0] VSG_CFG_IF_OFS    = 12'h810;
    localparam logic [11:0] VSG_CFG_W1_OFS    = 12'h814;
    localparam logic [11:0] VSG_CFG_SG_OFS    = 12'h818;
    localparam logic [11:0] VSG_CFG_W2_OFS    = 12'h81C;
    // Writable bits of each base register.
    localparam logic [31:0] VSG_IF_WMASK      = 32'hFFFF_FE00;
    localparam logic [31:0] VSG_W1_WMASK      = 32'hE000_0000;
    localparam logic [31:0] VSG_SG_WMASK      = 32'hFFFE_0000;
    localparam logic [31:0] VSG_W2_WMASK      = 32'hFC00_0000;
    localparam logic [31:0] VSG_BASE_RST      = 32'h0000_0000;
    // Page monitor status register inside the interface window.
    localparam logic [8:0]  VSG_PMON_OFS      = 9'h100;
    // Map RAM geometry, as longword indices.
    localparam int          VSG_MAP_WORDS     = 32768;
    localparam int          VSG_A32_ENTRIES   = 16384;
    localparam int          VSG_A24_ENTRIES   = 2048;
    localparam logic [14:0] VSG_A32_IDX_BASE  = 15'h0000;
    localparam logic [14:0] VSG_A24_IDX_BASE  = 15'h4000;
    localparam logic [14:0] VSG_OUT_IDX_BASE  = 15'h7800;
    localparam int          VSG_ZERO_BITS     = 5;
    // Entry field positions.
    localparam int          VSG_E_VALID       = 5;
    localparam int          VSG_E_WLOCK       = 9;
    localparam int          VSG_E_SUPER       = 10;
    localparam int          VSG_E_IOSEL       = 11;
    localparam int          VSG_E_MON_LO      = 12;
    localparam int          VSG_E_PAGE_LO     = 14;
    // Address modifier space decode and supervisory flag.
    localparam logic [2:0]  VSG_AM_A32        = 3'b001;
    localparam logic [2:0]  VSG_AM_A24        = 3'b111;
    localparam logic [5:0]  VSG_AM_A16_USER   = 6'h29;
    localparam logic [5:0]  VSG_AM_A16_SUPER  = 6'h2D;
    localparam int          VSG_AM_SUPER_BIT  = 2;

    typedef enum logic [4:0] {
        VSG_IDLE  = 5'b00001,
        VSG_CHECK = 5'b00010,
        VSG_PCI   = 5'b00100,
        VSG_MRD   = 5'b01000,
        VSG_DONE  = 5'b10000
    } vsg_state_e;
endpackage

// >>> tb/vsg_pci_target.sv
// Behavioural PCI target that answers the translator's inbound cycles.
module vsg_pci_target (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        pci_req,
    input  wire logic [31:0] pci_addr,
    input  wire logic        pci_io,
    output logic             pci_done,
    output logic      [31:0] pci_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    int          wait_n;
    logic        busy;
    logic [31:0] addr_r;
    logic        io_r;

    // Data changes every cycle outside a done pulse, so stale reads show up.
    always @(posedge clk_sys) begin
        pci_done <= 1'b0;
        pci_rdata <= pci_rdata + 32'h3C3C_0001;
        if (!rstn) begin
            busy <= 1'b0;
            pci_rdata <= 32'h1234_5678;
        end else if (pci_req) begin
            busy <= 1'b1;
            addr_r <= pci_addr;
            io_r <= pci_io;
            wait_n <= $urandom_range(0, 4);
        end else if (busy && wait_n == 0) begin
            busy <= 1'b0;
            pci_done <= 1'b1;
            pci_rdata <= addr_r ^ (io_r ? 32'h0F0F_0F0F : 32'h5A5A_A5A5);
        end else if (busy) begin
            wait_n <= wait_n - 1;
        end
    end
endmodule // vsg_pci_target

// >>> tb/tb.sv
// Self-checking bench for the inbound scatter-gather translator.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        cfg_req = 1'b0, cfg_we = 1'b0, cfg_ack;
    logic [11:0] cfg_addr = 12'h000;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
    logic        mem_req = 1'b0, mem_we = 1'b0, mem_ack;
    logic [31:0] mem_addr = 32'h0, mem_wdata = 32'h0, mem_rdata;
    logic        vme_req = 1'b0, vme_write = 1'b0, vme_ack, vme_berr;
    logic [5:0]  vme_am = 6'h00;
    logic [31:0] vme_addr = 32'h0, vme_rdata;
    logic [7:0]  vme_wdata = 8'h00;
    logic        pci_req, pci_io, pci_we, pci_done;
    logic [31:0] pci_addr, pci_rdata, got;
    logic [1:0]  ans;
    int          n_errors = 0, checks = 0, n_pci = 0, cyc = 0;
    logic [9:0]  mon_exp [4] = '{10'h0, 10'h0, 10'h0, 10'h0};
    logic [11:0] cofs [4] = '{12'h810, 12'h814, 12'h818, 12'h81C};
    logic [31:0] cmsk [4] = '{32'hFFFF_FE00, 32'hE000_0000,
                              32'hFFFE_0000, 32'hFC00_0000};
    logic [31:0] ce [9] = '{32'h220, 32'h220, 32'h420, 32'h420, 32'h1F,
                            32'h820, 32'h1020, 32'h2020, 32'h3020};
    logic [2:0]  clo [9] = '{3'h1, 3'h1, 3'h1, 3'h5, 3'h5, 3'h0, 3'h2,
                             3'h6, 3'h3};
    logic [8:0]  cw = 9'b000100001;

    vsg_translator #(.MON_W(10), .COMM_N(8)) uut (.clk_sys(clk_sys),
        .rstn(rstn), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .vme_req(vme_req), .vme_write(vme_write),
        .vme_am(vme_am), .vme_addr(vme_addr), .vme_wdata(vme_wdata),
        .vme_ack(vme_ack), .vme_berr(vme_berr), .vme_rdata(vme_rdata),
        .pci_req(pci_req), .pci_addr(pci_addr), .pci_io(pci_io),
        .pci_we(pci_we), .pci_done(pci_done), .pci_rdata(pci_rdata));
    vsg_pci_target far (.clk_sys(clk_sys), .rstn(rstn), .pci_req(pci_req),
        .pci_addr(pci_addr), .pci_io(pci_io), .pci_done(pci_done),
        .pci_rdata(pci_rdata));

    always #10 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        n_pci <= n_pci + ((pci_req === 1'b1) ? 1 : 0);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Bounded wait; a missing answer must not hang the run.
    task automatic wait_ans(input int k);
        int   n;
        logic d;
        n = 0;
        d = 1'b0;
        while (d !== 1'b1 && n < 60) begin
            @(negedge clk_sys);
            n++;
            d = (k == 0) ? cfg_ack : (k == 1) ? mem_ack : vme_ack | vme_berr;
        end
        chk({31'h0, d}, 32'h1);
    endtask

    task automatic cfg(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(negedge clk_sys);
        cfg_req = 1'b1;
        cfg_we = w;
        cfg_addr = a;
        cfg_wdata = wd;
        wait_ans(0);
        rd = cfg_rdata;
        cfg_req = 1'b0;
    endtask

    task automatic mem(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(negedge clk_sys);
        mem_req = 1'b1;
        mem_we = w;
        mem_addr = a;
        mem_wdata = wd;
        wait_ans(1);
        rd = mem_rdata;
        mem_req = 1'b0;
    endtask

    task automatic vme(input logic w, input logic [5:0] am,
                       input logic [31:0] a, input logic [7:0] wd);
        @(negedge clk_sys);
        vme_req = 1'b1;
        vme_write = w;
        vme_am = am;
        vme_addr = a;
        vme_wdata = wd;
        wait_ans(2);
        ans = {vme_berr, vme_ack};
        got = vme_rdata;
        vme_req = 1'b0;
    endtask

    // Fills one map entry before use, then makes one VME access through it.
    task automatic page(input logic a24, input logic [13:0] ix,
                        input logic [31:0] e, input logic w,
                        input logic [2:0] lo, input logic [31:0] r);
        logic [31:0] ma, va, pa;
        int          np;
        logic        ok;
        if (a24) ix = ix & 14'h07FF;
        ma = 32'h4000_0000 + (a24 ? 32'h1_0000 : 32'h0) + 32'({ix, 2'b00});
        va = a24 ? {r[31:24], ix[10:0], r[12:0]} : {r[31:27], ix, r[12:0]};
        mem(1'b1, ma, e, got);
        mem(1'b0, ma, 32'h0, got);
        chk(got, {e[31:5], 5'h00});
        np = n_pci;
        vme(w, {(a24 ? 3'b111 : 3'b001), lo}, va, r[7:0]);
        ok = e[5] && !(w && e[9]) && !(e[10] && !lo[2]);
        chk({30'h0, ans}, ok ? 32'h1 : 32'h2);
        chk(32'(n_pci - np), {31'h0, ok});
        if (ok) begin
            pa = {1'b0, e[31:14], va[12:2], 2'b00};
            chk(pci_addr, pa);
            chk({30'h0, pci_io, pci_we}, {30'h0, e[11], w});
            if (!w) chk(got, pa ^ (e[11] ? 32'h0F0F_0F0F : 32'h5A5A_A5A5));
            if (e[13:12] != 2'b00) mon_exp[e[13:12]]++;
        end
    endtask

    initial begin
        void'($urandom(49741));
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cfg(1'b0, cofs[i], 32'h0, got);
            chk(got, 32'h0);
            cfg(1'b1, cofs[i], 32'hFFFF_FFFF, got);
            cfg(1'b0, cofs[i], 32'h0, got);
            chk(got, cmsk[i]);
        end
        cfg(1'b1, 12'h820, 32'hFFFF_FFFF, got);
        cfg(1'b0, 12'h820, 32'h0, got);
        chk(got, 32'h0);
        // Bases go in before any memory-space access.
        cfg(1'b1, 12'h810, 32'h8000_0000, got);
        cfg(1'b1, 12'h818, 32'h4000_0000, got);
        mem(1'b0, 32'h2000_0000, 32'h0, got);
        chk(got, 32'h0);
        vme(1'b1, 6'h2D, 32'h0000_0003, 8'h5C);
        chk({30'h0, ans}, 32'h1);
        vme(1'b0, 6'h29, 32'h0000_0003, 8'h00);
        chk({24'h0, got[7:0]}, 32'h5C);
        vme(1'b0, 6'h10, 32'h0000_2000, 8'h00);
        chk({30'h0, ans}, 32'h2);
        for (int i = 0; i < 9; i++) begin
            page(i[0], 14'h3FFF - 14'(i), 32'hFFFF_C000 | ce[i], cw[i],
                 clo[i], $urandom);
        end
        for (int i = 0; i < 48; i++) begin
            page($urandom, $urandom, $urandom, $urandom, $urandom, $urandom);
        end
        mem(1'b0, 32'h8000_0100, 32'h0, got);
        chk(got, {2'b00, mon_exp[3], mon_exp[2], mon_exp[1]});
        give_verdict();
    end
endmodule // tb
